// [hw/rbt_pkg.sv]
// package: register map, field codes and limits for the reading buffer block
package rbt_pkg;
  // register indices (plain port, word per index)
  localparam logic [3:0] REG_CMD      = 4'h0; // write: action commands
  localparam logic [3:0] REG_SIZE     = 4'h1; // buffer size setting
  localparam logic [3:0] REG_SOURCE   = 4'h2; // reading source
  localparam logic [3:0] REG_CONTROL  = 4'h3; // storage control
  localparam logic [3:0] REG_SAMPLES  = 4'h4; // per-trigger sample count
  localparam logic [3:0] REG_CONT     = 4'h5; // continuous re-arm
  localparam logic [3:0] REG_STATUS   = 4'h6; // read: state
  localparam logic [3:0] REG_FREE     = 4'h7; // read: bytes free
  localparam logic [3:0] REG_RESERVED = 4'h8; // second-root alias of REG_CMD, reads zero; reserved bytes are in REG_FREE
  localparam logic [3:0] REG_COUNT    = 4'h9; // second-root alias of REG_SIZE; readings held are in REG_STATUS
  localparam logic [3:0] REG_SCANPTR  = 4'ha; // second-root alias of REG_SOURCE; scan-list pointer is in REG_STATUS
  localparam logic [3:0] REG_ALIAS    = 4'h8; // bit 3 picks second root alias

  // command bits in REG_CMD
  localparam int CMD_CLEAR   = 0;
  localparam int CMD_ARM     = 1;
  localparam int CMD_ABORT   = 2;
  localparam int CMD_READOUT = 3;
  localparam int CMD_SCAN    = 4;

  // limits
  localparam logic [10:0] SIZE_MIN     = 11'h002;
  localparam logic [10:0] SIZE_MAX     = 11'h400;
  localparam logic [10:0] SAMPLES_MIN  = 11'h001;
  localparam logic [10:0] SAMPLES_MAX  = 11'h400;
  localparam logic [10:0] SIZE_RST     = 11'h064;
  localparam logic [10:0] SAMPLES_RST  = 11'h001;
  localparam int          DEPTH        = 1024;
  localparam int          AW           = 10;
  localparam int          DW           = 32;
  localparam int          BYTES_PER    = 4;
  localparam logic [15:0] MEM_BYTES    = 16'h1000;
  localparam logic [7:0]  SCAN_LEN     = 8'h0a;
  localparam int          FIFO_DEPTH   = 16;

  typedef enum logic [1:0] {SRC_RAW, SRC_MATH, SRC_NONE} rbt_src_t;
  typedef enum logic [0:0] {CTL_OFF, CTL_FILL} rbt_ctl_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic          last;
  } rbt_word_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rbt_bus_t;
endpackage

// [hw/rbt_fifo.sv]
// fifo: parameterised width and depth, valid/ready on both sides
`timescale 1ns/1ps
module rbt_fifo
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      cnt;
  logic [PW-1:0]    next_wp;
  logic [PW-1:0]    next_rp;
  logic [PW:0]      next_cnt;
  logic             push;
  logic             pop;

  // full at depth words, empty at zero
  assign in_ready  = (cnt < (PW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb
  begin
    next_wp  = push ? wp + 1'b1 : wp;
    next_rp  = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage array, no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule

// [hw/rbt_top.sv]
// reading buffer storage and trigger model arming control
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
//
// Behaviour
// - clear discards every held reading
// - uncleared store overwrites; aborted leaves old
// - free query returns bytes free, reserved
// - buffer size 2..1024, readable, sets fill
// - source picks raw, math or nothing
// - control off stores nothing
// - other modes store unless source nothing
// - fill-once stops when size locations full
// - readout sends all held readings
// - both root aliases behave the same
// - arm leaves idle, returns when done
// - continuous re-arm loops to top
// - abort returns to top, idle unless continuous
// - abort resets scan pointer to first
// - sample count 1..1024 sets loop passes
module rbt_top
  import rbt_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  input  wire logic [DW-1:0] raw_reading,
  input  wire logic [DW-1:0] math_reading,
  input  wire logic          reading_valid,
  output logic               action_req,
  output logic               armed,
  output logic      [DW-1:0] out_data,
  output logic               out_last,
  output logic               out_valid,
  input  wire logic          out_ready
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} rbt_state_t;
  typedef enum logic [0:0] {RO_IDLE, RO_SEND} rbt_ro_t;

  // configuration state
  logic [10:0] size;
  logic [10:0] samples;
  rbt_src_t    source;
  rbt_ctl_t    control;
  logic        cont;
  logic [10:0] next_size;
  logic [10:0] next_samples;
  rbt_src_t    next_source;
  rbt_ctl_t    next_control;
  logic        next_cont;

  // trigger model state
  rbt_state_t  state;
  rbt_state_t  next_state;
  logic [10:0] pass_cnt;
  logic [10:0] next_pass_cnt;
  logic [7:0]  scan_ptr;
  logic [7:0]  next_scan_ptr;

  // storage state
  logic [DW-1:0] mem [DEPTH];
  logic [10:0]   wr_ptr;
  logic [10:0]   held;
  logic          storing;
  logic [10:0]   next_wr_ptr;
  logic [10:0]   next_held;
  logic          next_storing;

  // readout state
  rbt_ro_t       ro;
  rbt_ro_t       next_ro;
  logic [10:0]   rd_ptr;
  logic [10:0]   next_rd_ptr;

  logic          wr_en;
  logic [31:0]   wval;
  logic [3:0]    base;
  logic          cmd_wr;
  logic          fifo_in_ready;
  logic          push;
  logic [31:0]   next_rdata;
  logic [15:0]   reserved;
  rbt_word_t     fifo_in;
  rbt_word_t     fifo_out;

  // alias bit folds both roots onto one map
  assign base   = reg_addr & ~REG_ALIAS;
  assign wval   = reg_wdata;
  assign cmd_wr = reg_wr && base == REG_CMD;

  // configuration writes, clamped to legal range
  always_comb
  begin
    next_size    = size;
    next_samples = samples;
    next_source  = source;
    next_control = control;
    next_cont    = cont;
    if (reg_wr)
    begin
      case (base)
        REG_SIZE:
          if (wval[31:11] != '0 || wval[10:0] > SIZE_MAX)
            next_size = SIZE_MAX;
          else if (wval[10:0] < SIZE_MIN)
            next_size = SIZE_MIN;
          else
            next_size = wval[10:0];
        REG_SOURCE:
          if (wval[1:0] == 2'h1)
            next_source = SRC_MATH;
          else if (wval[1:0] == 2'h2)
            next_source = SRC_NONE;
          else
            next_source = SRC_RAW;
        REG_CONTROL:
          next_control = rbt_ctl_t'(wval[0]);
        REG_SAMPLES:
          if (wval[31:11] != '0 || wval[10:0] > SAMPLES_MAX)
            next_samples = SAMPLES_MAX;
          else if (wval[10:0] < SAMPLES_MIN)
            next_samples = SAMPLES_MIN;
          else
            next_samples = wval[10:0];
        REG_CONT:
          next_cont = wval[0];
        default:
          next_cont = cont;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size    <= SIZE_RST;
      samples <= SAMPLES_RST;
      source  <= SRC_RAW;
      control <= CTL_OFF;
      cont    <= 1'b0;
    end
    else
    begin
      size    <= next_size;
      samples <= next_samples;
      source  <= next_source;
      control <= next_control;
      cont    <= next_cont;
    end
  end

  // trigger model: idle, run passes, done
  always_comb
  begin
    next_state    = state;
    next_pass_cnt = pass_cnt;
    next_scan_ptr = scan_ptr;
    if (reading_valid && state == ST_RUN)
      next_scan_ptr = (scan_ptr == SCAN_LEN - 8'h01) ? 8'h00
                      : scan_ptr + 8'h01;
    case (state)
      ST_IDLE:
        if ((cmd_wr && wval[CMD_ARM]) || cont)
        begin
          next_state    = ST_RUN;
          next_pass_cnt = '0;
        end
      ST_RUN:
        if (reading_valid)
        begin
          if (pass_cnt + 11'h001 >= samples)
            next_state = ST_DONE;
          else
            next_pass_cnt = pass_cnt + 11'h001;
        end
      ST_DONE:
      begin
        next_pass_cnt = '0;
        next_state    = cont ? ST_RUN : ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
    // abort to top, idle unless continuous
    if (cmd_wr && wval[CMD_ABORT])
    begin
      next_pass_cnt = '0;
      next_state    = cont ? ST_RUN : ST_IDLE;
      next_scan_ptr = 8'h00;
    end
    else if (cmd_wr && wval[CMD_SCAN])
      next_scan_ptr = 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      pass_cnt <= '0;
      scan_ptr <= '0;
    end
    else
    begin
      state    <= next_state;
      pass_cnt <= next_pass_cnt;
      scan_ptr <= next_scan_ptr;
    end
  end

  assign action_req = (state == ST_RUN);
  assign armed      = (state != ST_IDLE);

  // write only when enabled and source set
  assign wr_en = storing && reading_valid && state == ST_RUN &&
                 control != CTL_OFF && source != SRC_NONE;

  // storage pointer and fill tracking
  always_comb
  begin
    next_wr_ptr  = wr_ptr;
    next_held    = held;
    next_storing = storing;
    // new store begins at location zero
    if (cmd_wr && wval[CMD_ARM] && state == ST_IDLE)
    begin
      next_wr_ptr  = '0;
      next_storing = (control == CTL_FILL);
    end
    else if (reg_wr && base == REG_CONTROL && wval[0])
    begin
      next_wr_ptr  = '0;
      next_storing = 1'b1;
    end
    else if (wr_en)
    begin
      next_wr_ptr = wr_ptr + 11'h001;
      // overwrite in place, older kept beyond
      if (wr_ptr >= held)
        next_held = wr_ptr + 11'h001;
      if (wr_ptr + 11'h001 >= size)
        next_storing = 1'b0;
    end
    if (reg_wr && base == REG_CONTROL && !wval[0])
      next_storing = 1'b0;
    if (cmd_wr && wval[CMD_CLEAR])
    begin
      next_held   = '0;
      next_wr_ptr = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr  <= '0;
      held    <= '0;
      storing <= 1'b0;
    end
    else
    begin
      wr_ptr  <= next_wr_ptr;
      held    <= next_held;
      storing <= next_storing;
    end
  end

  // reading memory; source select
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_ptr[AW-1:0]] <= (source == SRC_MATH) ? math_reading
                                                  : raw_reading;
  end

  // readout walk through held readings into the fifo
  assign push = (ro == RO_SEND) && fifo_in_ready;
  always_comb
  begin
    next_ro     = ro;
    next_rd_ptr = rd_ptr;
    case (ro)
      RO_IDLE:
        if (cmd_wr && wval[CMD_READOUT] && held != '0)
        begin
          next_ro     = RO_SEND;
          next_rd_ptr = '0;
        end
      RO_SEND:
        if (push)
        begin
          next_rd_ptr = rd_ptr + 11'h001;
          if (rd_ptr + 11'h001 >= held)
            next_ro = RO_IDLE;
        end
      default:
        next_ro = RO_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ro     <= RO_IDLE;
      rd_ptr <= '0;
    end
    else
    begin
      ro     <= next_ro;
      rd_ptr <= next_rd_ptr;
    end
  end

  assign fifo_in.data = mem[rd_ptr[AW-1:0]];
  assign fifo_in.last = (rd_ptr + 11'h001 >= held);

  rbt_fifo #(
    .WIDTH ($bits(rbt_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (fifo_in),
    .in_valid  (ro == RO_SEND),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );
  assign out_data = fifo_out.data;
  assign out_last = fifo_out.last;

  // reserved bytes from size, free is the rest
  assign reserved = 16'(size) * 16'(BYTES_PER);

  // read mux, data one cycle after strobe
  always_comb
  begin
    next_rdata = '0;
    if (reg_rd)
    begin
      case (base)
        REG_SIZE:     next_rdata = 32'(size);
        REG_SOURCE:   next_rdata = 32'(source);
        REG_CONTROL:  next_rdata = 32'(control);
        REG_SAMPLES:  next_rdata = 32'(samples);
        REG_CONT:     next_rdata = 32'(cont);
        REG_STATUS:   next_rdata = {5'h0, held, scan_ptr, 2'h0,
                                    ro == RO_SEND, storing,
                                    2'(state), armed, cont};
        // free bytes above, reserved bytes below
        REG_FREE:     next_rdata = {MEM_BYTES - reserved, reserved};
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= next_rdata;
  end
endmodule

// [tb/rbt_top_props.sv]
// checker: port properties of the reading buffer block
`timescale 1ns/1ps
module rbt_top_props
  import rbt_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [3:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire logic          action_req,
  input wire logic          armed,
  input wire logic [DW-1:0] out_data,
  input wire logic          out_last,
  input wire logic          out_valid,
  input wire logic          out_ready
);
  logic [2:0]  idx;
  logic [10:0] size;
  logic [10:0] next_size;
  logic        cont;
  logic        next_cont;
  logic [31:0] free;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // alias bit folds onto the base index
  assign idx  = reg_addr[2:0];
  assign free = {MEM_BYTES - 16'(size) * 16'(BYTES_PER),
                 16'(size) * 16'(BYTES_PER)};

  // shadow of size and re-arm settings
  always_comb
  begin
    next_size = size;
    next_cont = cont;
    if (reg_wr && idx == REG_SIZE[2:0])
      next_size = reg_wdata < 32'(SIZE_MIN) ? SIZE_MIN :
        reg_wdata > 32'(SIZE_MAX) ? SIZE_MAX : reg_wdata[10:0];
    if (reg_wr && idx == REG_CONT[2:0])
      next_cont = reg_wdata[0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size <= SIZE_RST;
      cont <= 1'b0;
    end
    else
    begin
      size <= next_size;
      cont <= next_cont;
    end
  end

  sequence s_cmd(int b);
    reg_wr && idx == 3'h0 && reg_wdata[b] && reg_wdata[2:1] != 2'h3;
  endsequence
  sequence s_rd(logic [2:0] i);
    reg_rd && idx == i;
  endsequence
  sequence s_cont_on;
    reg_wr && idx == REG_CONT[2:0] && reg_wdata[0];
  endsequence

  arm_run_a: assert property (s_cmd(CMD_ARM) ##0 !armed |=> action_req)
    else $error("arm gave no run");
  req_armed_a: assert property (action_req |-> armed)
    else $error("running while idle");
  stay_idle_a: assert property (!armed && !cont && !reg_wr |=> !armed)
    else $error("left idle uncommanded");
  abort_idle_a: assert property (s_cmd(CMD_ABORT) ##0 !cont |=> !armed)
    else $error("abort left armed");
  abort_top_a: assert property (s_cmd(CMD_ABORT) ##0 cont |=> armed)
    else $error("abort with re-arm went idle");
  cont_arm_a: assert property (s_cont_on |=> ##[0:1] armed)
    else $error("re-arm stayed idle");
  size_read_a: assert property (s_rd(REG_SIZE[2:0]) |=>
    reg_rdata == 32'(size))
    else $error("size readback wrong");
  free_read_a: assert property (s_rd(REG_FREE[2:0]) |=> reg_rdata == free)
    else $error("free bytes wrong");
  stream_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled word changed");
endmodule

bind rbt_top rbt_top_props i_rbt_top_props (.clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .action_req, .armed,
  .out_data, .out_last, .out_valid, .out_ready);

// [tb/rbt_host.sv]
// host model: register bus master and stalling readout sink
`timescale 1ns/1ps
module rbt_host
  import rbt_pkg::*;
(
  input  wire logic          clk,
  output logic      [3:0]    reg_addr,
  output logic      [31:0]   reg_wdata,
  output logic               reg_wr,
  output logic               reg_rd,
  input  wire logic [31:0]   reg_rdata,
  input  wire logic [DW-1:0] out_data,
  input  wire logic          out_last,
  input  wire logic          out_valid,
  output logic               out_ready
);
  logic [DW:0] got[$];

  initial
  begin
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    out_ready = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // capture accepted words, stall at random
  always @(posedge clk)
  begin
    if (out_valid && out_ready)
      got.push_back({out_last, out_data});
    out_ready <= ($urandom % 4) != 0;
  end
endmodule

// [tb/test_rbt_top.sv]
// testbench: random and corner runs of the reading buffer block
`timescale 1ns/1ps
module test_rbt_top;
  import rbt_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [3:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  logic [DW-1:0] raw_reading = '0;
  logic [DW-1:0] math_reading = '0;
  logic          reading_valid = 1'b0;
  logic          action_req;
  logic          armed;
  logic [DW-1:0] out_data;
  logic          out_last;
  logic          out_valid;
  logic          out_ready;
  int            failures = 0;
  int            checks = 0;
  int            vals[4] = '{1, 2, 1024, 2000};
  logic [DW-1:0] held[$];
  logic [31:0]   v;

  always #10 clk = ~clk;

  rbt_top i_rbt_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .raw_reading, .math_reading, .reading_valid, .action_req,
    .armed, .out_data, .out_last, .out_valid, .out_ready);
  rbt_host i_rbt_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .out_data, .out_last, .out_valid, .out_ready);

  function automatic logic [31:0] clamp(input logic [31:0] x, input int lo);
    return x < lo ? 32'(lo) : x > 32'h400 ? 32'h400 : x;
  endfunction

  // free bytes above, reserved bytes below
  function automatic logic [31:0] room(input logic [31:0] c);
    return {16'(32'(MEM_BYTES) - 4 * c), 16'(4 * c)};
  endfunction

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string w, input logic [32:0] e, s);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    i_rbt_host.rd(a, v);
    check("register", {1'b0, e}, {1'b0, v});
  endtask

  task automatic wait_armed(input logic want);
    int n;
    for (n = 0; n < 200 && armed !== want; n++)
      @(posedge clk);
    check("armed", want, armed);
    if (armed !== want)
      give_verdict;
  endtask

  // readings on both inputs, keep tracks the stored ones
  task automatic feed(input int k, input int src, input int keep);
    logic [31:0] r;
    logic [31:0] m;
    repeat (k)
    begin
      r = $urandom;
      m = $urandom;
      @(posedge clk);
      raw_reading   <= r;
      math_reading  <= m;
      reading_valid <= 1'b1;
      @(posedge clk);
      reading_valid <= 1'b0;
      if (keep-- > 0)
        held.push_back(src == 0 ? r : m);
    end
  endtask

  task automatic readout;
    int n;
    i_rbt_host.got.delete();
    i_rbt_host.wr(REG_CMD, 32'h1 << CMD_READOUT);
    for (n = 0; n < 300 && i_rbt_host.got.size() < held.size(); n++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    check("count", held.size(), i_rbt_host.got.size());
    foreach (held[i])
      check("word", {i == held.size() - 1, held[i]}, i_rbt_host.got[i]);
    if (n == 300)
      give_verdict;
  endtask

  initial
  begin
    int sz;
    v = $urandom(97780);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(REG_SIZE, 32'(SIZE_RST));
    rdchk(REG_SAMPLES, 32'(SAMPLES_RST));
    rdchk(REG_SOURCE, 32'h0);
    rdchk(REG_CMD, 32'h0);
    // size and sample corners, then random, size through both roots
    for (int i = 0; i < 8; i++)
    begin
      sz = i < 4 ? vals[i] : 2 + $urandom % 1023;
      i_rbt_host.wr({i[0], REG_SIZE[2:0]}, sz);
      rdchk({i[1], REG_SIZE[2:0]}, clamp(sz, 2));
      rdchk(REG_FREE, room(clamp(sz, 2)));
      i_rbt_host.wr(REG_SAMPLES, sz - 1);
      rdchk(REG_SAMPLES, clamp(sz - 1, 1));
    end
    // store passes: raw, math, nothing, disabled
    for (int p = 0; p < 4; p++)
    begin
      if (p < 2)
      begin
        sz = 2 + $urandom % 7;
        i_rbt_host.wr(REG_CMD, 32'h1 << CMD_CLEAR);
        held.delete();
        readout();
        i_rbt_host.wr(REG_SIZE, sz);
      end
      i_rbt_host.wr(REG_SAMPLES, sz + 2);
      i_rbt_host.wr(REG_SOURCE, p == 1 ? 1 : p == 2 ? 2 : 0);
      i_rbt_host.wr(REG_CONTROL, p < 3);
      i_rbt_host.wr(REG_CMD, 32'h1 << CMD_ARM);
      wait_armed(1'b1);
      feed(sz + 2, p, p < 2 ? sz : 0);
      wait_armed(1'b0);
      readout();
    end
    // continuous re-arm, single sample per pass
    i_rbt_host.wr(REG_SAMPLES, 1);
    i_rbt_host.wr(REG_CONT, 1);
    wait_armed(1'b1);
    i_rbt_host.wr(REG_CMD, 32'h1 << CMD_SCAN);
    feed(3, 0, 0);
    #1 check("armed", 1, armed);
    i_rbt_host.rd(REG_STATUS, v);
    check("scan", 33'h3, 33'(v[15:8]));
    i_rbt_host.wr(REG_CMD, 32'h1 << CMD_ABORT);
    #1 check("armed", 1, armed);
    i_rbt_host.rd(REG_STATUS, v);
    check("scan", 33'h0, 33'(v[15:8]));
    i_rbt_host.wr(REG_CONT, 0);
    i_rbt_host.wr(REG_CMD, 32'h1 << CMD_ABORT | 32'h1 << CMD_SCAN);
    wait_armed(1'b0);
    give_verdict;
  end
endmodule
